// ---- rtl/fsr_consts.svh ----
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

`define FSR_CMD_CLEAR_FAULTS 8'h03
`define FSR_OFS_EVENT_RECORD 8'hD0
`define FSR_OFS_IGNORE_SELECT 8'hD1
`define FSR_OFS_RECOVERY_SELECT 8'hD2
`define FSR_OFS_OV_THRESHOLD 8'hD3
`define FSR_OFS_UV_THRESHOLD 8'hD4
`define FSR_OFS_CC_THRESHOLD 8'hD5
`define FSR_OFS_AVG_OC_THRESHOLD 8'hD6

`define FSR_RST_EVENT_RECORD 16'h0000
`define FSR_RST_IGNORE_SELECT 16'h0049
`define FSR_RST_OV_THRESHOLD 8'h06
`define FSR_RST_UV_THRESHOLD 8'h01
`define FSR_RST_CC_THRESHOLD 8'h07
`define FSR_RST_AVG_OC_THRESHOLD 8'h07
`define FSR_RST_RECOVERY_SELECT 16'h0000
`define FSR_LOAD_WAIT 2'h2

`define FSR_STATUS_VALID 16'h03FF
`define FSR_FAULT_VALID 16'h03FC
`define FSR_THRESH_VALID 8'h07
`define FSR_FAULT_LSB 2
`define FSR_FAULT_MSB 9

`endif

// ---- rtl/fsr_pkg.sv ----
package fsr_pkg;
    typedef enum logic [1:0] {
        FSR_LOAD = 2'b01,
        FSR_RUN = 2'b10
    } fsr_state_t;
endpackage : fsr_pkg

// ---- rtl/fsr_fault_regs.sv ----
`timescale 1ns/1ps
`include "fsr_consts.svh"
// Notes on behaviour
// - Status word bits 9..2 record faults, bit 1 temp warning, bit 0 comm warning.
// - A set status bit holds until host writes 0, clear-faults command, or reset.
// - Every triggered fault is recorded regardless of its mask bit.
// - Mask word bits 9..2 per fault, other bits unused, reset value 0049h.
// - Masked fault triggers no protective action; operation continues normally.
// - Unmasked fault triggers hiccup or latch-off per its response bit.
// - Response word bits 9..2: 1 selects hiccup, 0 selects latch-off.
// - Response word resets to 0000h, then loads from the synchronised recovery select pin level after reset.
// - Overvoltage threshold selector, bits 2..0 valid, resets to 06h.
// - Undervoltage threshold selector, bits 7..3 unused, bits 2..0 valid.
// - Constant-current threshold selector, bits 2..0 valid, resets to 07h.
// - Average overcurrent threshold selector, bits 2..0 valid, resets to 07h.
// - After clear-faults, still-present faults set again at once and alert again.
module fsr_fault_regs
    import fsr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    input wire logic cmd_send,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    input wire logic [15:0] fault_events,
    input wire logic recovery_select_pin,
    output logic [15:0] fault_event_record,
    output logic [15:0] fault_ignore_select,
    output logic [15:0] fault_recovery_select,
    output logic [7:0] output_overvoltage_threshold,
    output logic [7:0] output_undervoltage_threshold,
    output logic [7:0] input_current_regulation_threshold,
    output logic [7:0] average_overcurrent_threshold,
    output logic fault_hiccup,
    output logic fault_latch_off,
    output logic alert_pin
);

// ==========================================================================
// Input synchronisers
logic [15:0] ev_sync;
logic pin_sync;

fsr_sync #(
    .WIDTH(16)
) fsr_sync_event_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .level_in(fault_events),
    .level_sync(ev_sync)
);

fsr_sync #(
    .WIDTH(1)
) fsr_sync_pin_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .level_in(recovery_select_pin),
    .level_sync(pin_sync)
);

// ==========================================================================
// Register bank
fsr_state_t state;
fsr_state_t next_state;
logic [15:0] next_status;
logic [15:0] next_mask;
logic [15:0] next_resp;
logic [7:0] next_ov;
logic [7:0] next_uv;
logic [7:0] next_cc;
logic [7:0] next_avg;
logic [15:0] next_rdata;
logic next_alert;
logic [1:0] load_cnt;
logic [1:0] next_load_cnt;
logic [15:0] active;
logic [15:0] trigger;

// Bit 4 of the event inputs is the average overcurrent fault.
assign trigger = ev_sync & `FSR_STATUS_VALID;

always_comb begin
    next_state = state;
    next_load_cnt = load_cnt;
    next_status = fault_event_record;
    next_mask = fault_ignore_select;
    next_resp = fault_recovery_select;
    next_ov = output_overvoltage_threshold;
    next_uv = output_undervoltage_threshold;
    next_cc = input_current_regulation_threshold;
    next_avg = average_overcurrent_threshold;
    next_rdata = cmd_rdata;
    case (state)
        FSR_LOAD: begin
            // Wait for the synchroniser to carry the pin level, then copy it.
            if (load_cnt == `FSR_LOAD_WAIT) begin
                next_resp = pin_sync ? `FSR_FAULT_VALID : 16'h0000;
                next_state = FSR_RUN;
            end else begin
                next_load_cnt = load_cnt + 2'h1;
            end
        end
        FSR_RUN: begin
            if (cmd_send && cmd_code == `FSR_CMD_CLEAR_FAULTS) begin
                next_status = 16'h0000;
            end
            if (cmd_wr) begin
                case (cmd_code)
                    `FSR_OFS_EVENT_RECORD: next_status = fault_event_record & cmd_wdata;
                    `FSR_OFS_IGNORE_SELECT: next_mask = cmd_wdata & `FSR_FAULT_VALID;
                    `FSR_OFS_RECOVERY_SELECT: next_resp = cmd_wdata & `FSR_FAULT_VALID;
                    `FSR_OFS_OV_THRESHOLD: next_ov = cmd_wdata[7:0] & `FSR_THRESH_VALID;
                    `FSR_OFS_UV_THRESHOLD: next_uv = cmd_wdata[7:0] & `FSR_THRESH_VALID;
                    `FSR_OFS_CC_THRESHOLD: next_cc = cmd_wdata[7:0] & `FSR_THRESH_VALID;
                    `FSR_OFS_AVG_OC_THRESHOLD: next_avg = cmd_wdata[7:0] & `FSR_THRESH_VALID;
                    default: begin
                    end
                endcase
            end
        end
        default: begin
            next_state = FSR_LOAD;
        end
    endcase
    // Events win over any clear, so a lasting fault sets again at once.
    next_status = (next_status | trigger) & `FSR_STATUS_VALID;
    if (cmd_rd) begin
        case (cmd_code)
            `FSR_OFS_EVENT_RECORD: next_rdata = fault_event_record;
            `FSR_OFS_IGNORE_SELECT: next_rdata = fault_ignore_select;
            `FSR_OFS_RECOVERY_SELECT: next_rdata = fault_recovery_select;
            `FSR_OFS_OV_THRESHOLD: next_rdata = {8'h00, output_overvoltage_threshold};
            `FSR_OFS_UV_THRESHOLD: next_rdata = {8'h00, output_undervoltage_threshold};
            `FSR_OFS_CC_THRESHOLD: next_rdata = {8'h00, input_current_regulation_threshold};
            `FSR_OFS_AVG_OC_THRESHOLD: next_rdata = {8'h00, average_overcurrent_threshold};
            default: next_rdata = 16'h0000;
        endcase
    end
    next_alert = |next_status;
end

always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        state <= FSR_LOAD;
        load_cnt <= 2'h0;
        fault_event_record <= `FSR_RST_EVENT_RECORD;
        fault_ignore_select <= `FSR_RST_IGNORE_SELECT;
        fault_recovery_select <= `FSR_RST_RECOVERY_SELECT;
        output_overvoltage_threshold <= `FSR_RST_OV_THRESHOLD;
        output_undervoltage_threshold <= `FSR_RST_UV_THRESHOLD;
        input_current_regulation_threshold <= `FSR_RST_CC_THRESHOLD;
        average_overcurrent_threshold <= `FSR_RST_AVG_OC_THRESHOLD;
        cmd_rdata <= 16'h0000;
        alert_pin <= 1'b0;
    end else begin
        state <= next_state;
        load_cnt <= next_load_cnt;
        fault_event_record <= next_status;
        fault_ignore_select <= next_mask;
        fault_recovery_select <= next_resp;
        output_overvoltage_threshold <= next_ov;
        output_undervoltage_threshold <= next_uv;
        input_current_regulation_threshold <= next_cc;
        average_overcurrent_threshold <= next_avg;
        cmd_rdata <= next_rdata;
        alert_pin <= next_alert;
    end
end

// ==========================================================================
// Protective action
// Only unmasked live faults act; masked ones leave operation untouched.
assign active = trigger & ~fault_ignore_select & `FSR_FAULT_VALID;

logic next_hiccup;
logic next_latch;

always_comb begin
    next_hiccup = |(active & fault_recovery_select);
    next_latch = |(active & ~fault_recovery_select);
end

always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        fault_hiccup <= 1'b0;
        fault_latch_off <= 1'b0;
    end else begin
        fault_hiccup <= next_hiccup;
        fault_latch_off <= next_latch;
    end
end

endmodule : fsr_fault_regs

// ==========================================================================
// Two-flip-flop synchroniser
// Only the second stage is read, so a metastable first stage never reaches logic.
module fsr_sync
    import fsr_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] level_sync
);

logic [WIDTH-1:0] level_meta;

always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        level_meta <= '0;
        level_sync <= '0;
    end else begin
        level_meta <= level_in;
        level_sync <= level_meta;
    end
end

endmodule : fsr_sync

// ---- testbench/fsr_host_model.sv ----
`timescale 1ns/1ps
// ====
// Host side of the command port; idle lines carry the inverted code and data.
module fsr_host_model
    import fsr_pkg::*;
(
    input wire logic clk,
    output logic cmd_wr,
    output logic cmd_rd,
    output logic cmd_send,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata
);
    initial {cmd_wr, cmd_rd, cmd_send, cmd_code, cmd_wdata} = 27'h0;
    task automatic go(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        {cmd_wr, cmd_rd, cmd_send, cmd_code, cmd_wdata} <= {k == 2'd1, k == 2'd2, k == 2'd3, c, d};
        @(posedge clk);
        {cmd_wr, cmd_rd, cmd_send, cmd_code, cmd_wdata} <= {3'b000, ~c, ~d};
    endtask : go
endmodule : fsr_host_model

// ---- testbench/fsr_fault_regs_assertions.sv ----
`timescale 1ns/1ps
// ====
// Port checks.
module fsr_fault_regs_assertions
    import fsr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_wr,
    input wire logic cmd_send,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] fault_events,
    input wire logic [15:0] fault_event_record,
    input wire logic [15:0] fault_ignore_select,
    input wire logic [15:0] fault_recovery_select,
    input wire logic fault_hiccup,
    input wire logic fault_latch_off,
    input wire logic alert_pin
);
    wire [15:0] r = fault_event_record;
    wire [9:0] e = fault_events[9:0];
    logic [1:0] up;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_status_unused: assert property (r[15:10] == 6'h00) else $error("status spare");
    a_status_sticky: assert property (!cmd_wr && !cmd_send |=> (r & $past(r)) == $past(r)) else $error("sticky");
    a_event_seen: assert property (up == 2'd3 |-> ($past(e, 3) & ~r[9:0]) == 10'h000) else $error("lost");
    a_clear_empties: assert property (cmd_send && cmd_code == 8'h03 && $past(e) == 10'h000
        && $past(e, 2) == 10'h000 |=> r == 16'h0000) else $error("clear");
    a_alert_follows: assert property (alert_pin == (r != 16'h0000)) else $error("alert");
    a_config_spare: assert property (((fault_ignore_select & 16'hFC02) | (fault_recovery_select & 16'hFC03)) == 16'h0000)
        else $error("config spare");
    a_mask_spare_hold: assert property (!$rose(fault_ignore_select[0])) else $error("mask spare");
    a_hiccup_cause: assert property (fault_hiccup |->
        |(r[9:2] & ~$past(fault_ignore_select[9:2]) & $past(fault_recovery_select[9:2]))) else $error("hiccup");
    a_latch_cause: assert property (fault_latch_off |->
        |(r[9:2] & ~$past(fault_ignore_select[9:2]) & ~$past(fault_recovery_select[9:2]))) else $error("latch");
    c_clear: cover property (cmd_send && cmd_code == 8'h03 && r != 16'h0000);
    c_hiccup: cover property (fault_hiccup);
    c_latch: cover property (fault_latch_off);
endmodule : fsr_fault_regs_assertions
bind fsr_fault_regs fsr_fault_regs_assertions fsr_fault_regs_assertions_inst (.*);

// ---- testbench/tb_fsr_fault_regs.sv ----
`timescale 1ns/1ps
// ====
// Bench.
module tb_fsr_fault_regs
    import fsr_pkg::*;
;
    logic clk = 0, sys_rst = 1, pin = 0, wr, rd, sd, hic, lat, al;
    logic [7:0] cd, c, ov, uv, cc, av;
    logic [15:0] wd, rdat, ev = 16'h0000, d, rec, ign, rsp;
    logic [15:0] rv [8] = '{16'h0000, 16'h0049, 16'h0000, 16'h0006, 16'h0001, 16'h0007, 16'h0007, 16'h0000};
    int mismatches = 0, checks = 0, seed = 32'hE5572F51;
    always #20 clk = ~clk;
    fsr_host_model fsr_host_model_inst (.clk(clk), .cmd_wr(wr), .cmd_rd(rd), .cmd_send(sd), .cmd_code(cd),
        .cmd_wdata(wd));
    fsr_fault_regs fsr_fault_regs_inst (.clk(clk), .sys_rst(sys_rst), .cmd_wr(wr), .cmd_rd(rd), .cmd_send(sd),
        .cmd_code(cd), .cmd_wdata(wd), .cmd_rdata(rdat), .fault_events(ev), .recovery_select_pin(pin),
        .fault_event_record(rec), .fault_ignore_select(ign), .fault_recovery_select(rsp),
        .output_overvoltage_threshold(ov), .output_undervoltage_threshold(uv),
        .input_current_regulation_threshold(cc), .average_overcurrent_threshold(av),
        .fault_hiccup(hic), .fault_latch_off(lat), .alert_pin(al));
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        checks++;
        if (g !== x) begin
            mismatches++;
            $display("Error %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [15:0] x);
        fsr_host_model_inst.go(2'd2, a, 16'h0000);
        #1 chk(rdat, x);
    endtask : rdc
    function automatic logic [15:0] fx(input logic [7:0] a, input logic [15:0] v);
        return v & (a < 8'hD3 ? 16'h03FC : 16'h0007);
    endfunction : fx
    task automatic conclude();
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    initial begin
        #100000 mismatches++;
        conclude();
    end
    initial begin
        d = 16'($random(seed));
        pin <= d[0];
        rv[2] = d[0] ? 16'h03FC : 16'h0000;
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 8; i++) rdc(8'hD0 + 8'(i), rv[i]);
        repeat (24) begin
            c = 8'hD1 + 8'($unsigned($random(seed)) % 6);
            d = 16'($random(seed));
            fsr_host_model_inst.go(2'd1, c, d);
            rv[3'(c - 8'hD0)] = fx(c, d);
            rdc(c, fx(c, d));
        end
        chk(ign, rv[1]);
        chk(rsp, rv[2]);
        chk({ov, uv}, {rv[3][7:0], rv[4][7:0]});
        chk({cc, av}, {rv[5][7:0], rv[6][7:0]});
        fsr_host_model_inst.go(2'd1, 8'hD1, 16'h0000);
        fsr_host_model_inst.go(2'd1, 8'hD2, 16'hFFEF);
        @(posedge clk) ev <= 16'hFE10;
        repeat (5) @(posedge clk);
        #1 chk(rec, 16'h0210);
        chk(16'({al, hic, lat}), 16'h0007);
        fsr_host_model_inst.go(2'd1, 8'hD1, 16'hFFFF);
        repeat (4) @(posedge clk);
        #1 chk(16'({al, hic, lat}), 16'h0004);
        fsr_host_model_inst.go(2'd3, 8'h03, 16'h0000);
        #1 chk(rec, 16'h0210);
        @(posedge clk) ev <= 16'h0000;
        repeat (5) @(posedge clk);
        fsr_host_model_inst.go(2'd1, 8'hD0, 16'hFDFF);
        #1 chk(rec, 16'h0010);
        fsr_host_model_inst.go(2'd3, 8'h03, 16'h0000);
        #1 chk(rec | 16'(al), 16'h0000);
        conclude();
    end
endmodule : tb_fsr_fault_regs
